// ==== slow_timer_pkg.sv ====
// Package for the slow clock system timer: register map, reset values,
// field positions, counts and the packed register layouts.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package slow_timer_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_TIMER_COMMAND  = 8'h00;
  localparam logic [7:0] OFS_INTERVAL_MODE  = 8'h04;
  localparam logic [7:0] OFS_WATCHDOG_MODE  = 8'h08;
  localparam logic [7:0] OFS_PRESCALER_MODE = 8'h0C;
  localparam logic [7:0] OFS_TIMER_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK_VIEW  = 8'h1C;
  localparam logic [7:0] OFS_SECONDS_ALARM  = 8'h20;
  localparam logic [7:0] OFS_SECONDS_COUNT  = 8'h24;

  // Values after reset
  localparam logic [31:0] RST_INTERVAL_MODE  = 32'h0000_0000;
  localparam logic [31:0] RST_WATCHDOG_MODE  = 32'h0002_0000;
  localparam logic [31:0] RST_PRESCALER_MODE = 32'h0000_8000;
  localparam logic [31:0] RST_SECONDS_ALARM  = 32'h0000_0000;

  // Field positions
  localparam int BIT_RESTART_CMD    = 0;
  localparam int BIT_INTERVAL_FLAG  = 0;
  localparam int BIT_WATCHDOG_FLAG  = 1;
  localparam int BIT_TICK_FLAG      = 2;
  localparam int BIT_ALARM_FLAG     = 3;
  localparam int NUM_SOURCES        = 4;

  // Counts of slow clock cycles
  localparam logic [6:0] WDOG_DIV_LAST   = 7'h7F;  // Divide by 128
  localparam logic [3:0] PIN_LOW_CYCLES  = 4'h8;   // Overflow pin low time

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog mode layout
  typedef struct packed {
    logic [13:0] unused;
    logic        overflow_pin_enable;
    logic        overflow_reset_enable;
    logic [15:0] watchdog_load_value;
  } watchdog_mode_t;

  // Sticky status and mask layout
  typedef struct packed {
    logic alarm_match_flag;
    logic seconds_tick_flag;
    logic watchdog_expired_flag;
    logic interval_elapsed_flag;
  } timer_flags_t;

endpackage : slow_timer_pkg

// ==== slow_clock_system_timer.sv ====
// Slow clock system timer: interval counter, watchdog and seconds counter
// with alarm, all stepped by the slow clock, behind an AXI4-Lite slave.
// Assumes SYS_CLK is much faster than the slow clock pin, which is
// sampled and edge detected here; IRQ is ORed with other sources outside.
//
// Overview of operation
// - Watchdog is 16-bit; zero loads 65536 x 128
// - Reset enable bit gates the internal reset
// - Pin enable drives overflow output low 8 cycles
// - Prescaler sets slow cycles per second; zero=65536
// - Status bit 0: interval reached zero, read clears
// - Status bit 1: watchdog reached zero, read clears
// - Status bit 2: seconds incremented, read clears
// - Status bit 3: alarm matched, read clears
// - Enable-set register sets mask bits on ones
// - Enable-clear register clears mask bits on ones
// - Mask view returns enabled sources
// - 20-bit alarm compared; zero gives longest delay
// - Count view returns seconds, upper bits zero
// - Interrupt output is OR-able onto shared line
// - Interval counter 16-bit, flags, reloads; write restarts
// - Restart command reloads watchdog and divider
// - Prescaler mode write restarts divider, clears seconds
// - Seconds equal alarm sets alarm flag
`timescale 1ns/1ps
`default_nettype none

module slow_clock_system_timer
  import slow_timer_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  // Slow clock pin
  input  wire logic        SLOW_CLOCK,
  // AXI4-Lite write address
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  // AXI4-Lite write response
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  // AXI4-Lite read data
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Timer outputs
  output var  logic        IRQ,
  output var  logic        OVERFLOW_OUT_N,
  output var  logic        RESET_REQ
);

  // Zero programs the longest count of 65536
  function automatic logic [16:0] load_count(input logic [15:0] value);
    load_count = (value == 16'h0000) ? 17'h1_0000 : {1'b0, value};
  endfunction : load_count

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'h0) && (addr <= OFS_SECONDS_COUNT);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////
  // Slow clock synchroniser and edge detect

  logic        slow_meta;
  logic        slow_sync;
  logic        slow_last;
  logic        slow_level;
  logic        slow_agree;
  logic        slow_tick;

  // Three stages; a level change counts once the second and third agree
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_last <= 1'b0;
    end else begin
      slow_meta <= SLOW_CLOCK;
      slow_sync <= slow_meta;
      slow_last <= slow_sync;
    end
  end

  assign slow_agree = (slow_sync == slow_last);

  // Accepted level; idles low like the pin so reset gives no false edge
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      slow_level <= 1'b0;
    end else if (slow_agree) begin
      slow_level <= slow_last;
    end
  end

  assign slow_tick = slow_agree && slow_last && !slow_level;

  ////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [7:0]     wr_addr;
  logic           aw_held;
  logic [31:0]    wr_data;
  logic [3:0]     wr_strb;
  logic           w_held;
  logic           do_write;
  logic           do_read;
  logic           status_read;
  logic [31:0]    read_word;

  assign do_write    = aw_held && w_held && !S_AXI_BVALID;
  assign do_read     = S_AXI_ARVALID && S_AXI_ARREADY;
  assign status_read = do_read && (S_AXI_ARADDR == OFS_TIMER_STATUS);

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = do_write && (wr_addr == ofs);
  endfunction : wr_hit

  // Write address and data are taken in either order
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held       <= 1'b1;
        wr_addr       <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end else if (do_write) begin
        aw_held       <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held       <= 1'b1;
        wr_data      <= S_AXI_WDATA;
        wr_strb      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end else if (do_write) begin
        w_held       <= 1'b0;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Write response follows the register update
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode registers

  logic [15:0]    interval_load_value;
  watchdog_mode_t wdog_mode;
  logic [15:0]    seconds_prescaler;
  logic [19:0]    alarm_compare_value;
  logic [31:0]    wdog_word;
  logic [31:0]    interval_word;
  logic [31:0]    presc_word;
  logic [31:0]    alarm_word;

  // Stored words with the pending write merged in
  assign wdog_word     = merge(wdog_mode, wr_data, wr_strb);
  assign interval_word = merge({16'h0000, interval_load_value}, wr_data, wr_strb);
  assign presc_word    = merge({16'h0000, seconds_prescaler}, wr_data, wr_strb);
  assign alarm_word    = merge({12'h000, alarm_compare_value}, wr_data, wr_strb);

  // Software-written settings; reserved bits stay zero
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      interval_load_value <= RST_INTERVAL_MODE[15:0];
      wdog_mode           <= watchdog_mode_t'(RST_WATCHDOG_MODE);
      seconds_prescaler   <= RST_PRESCALER_MODE[15:0];
      alarm_compare_value <= RST_SECONDS_ALARM[19:0];
    end else begin
      if (wr_hit(OFS_INTERVAL_MODE)) begin
        interval_load_value <= interval_word[15:0];
      end
      if (wr_hit(OFS_WATCHDOG_MODE)) begin
        wdog_mode <= watchdog_mode_t'({14'h0000, wdog_word[17:0]});
      end
      if (wr_hit(OFS_PRESCALER_MODE)) begin
        seconds_prescaler <= presc_word[15:0];
      end
      if (wr_hit(OFS_SECONDS_ALARM)) begin
        alarm_compare_value <= alarm_word[19:0];
      end
    end
  end

  logic restart_cmd;

  assign restart_cmd = wr_hit(OFS_TIMER_COMMAND) && wr_strb[0]
                       && wr_data[BIT_RESTART_CMD];

  ////////////////////////////////////////////////////////////////////////
  // Interval counter

  logic [16:0]    interval_count;
  logic           interval_event;

  assign interval_event = slow_tick && (interval_count == 17'h0_0001);

  // Counts down, flags at zero and reloads; a mode write restarts it
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      interval_count <= load_count(RST_INTERVAL_MODE[15:0]);
    end else if (wr_hit(OFS_INTERVAL_MODE)) begin
      interval_count <= load_count(interval_word[15:0]);
    end else if (interval_event) begin
      interval_count <= load_count(interval_load_value);
    end else if (slow_tick) begin
      interval_count <= interval_count - 17'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watchdog

  logic [6:0]     wdog_div;
  logic [16:0]    wdog_count;
  logic           wdog_step;
  logic           wdog_event;
  logic [3:0]     pin_left;

  assign wdog_step  = slow_tick && (wdog_div == WDOG_DIV_LAST);
  assign wdog_event = wdog_step && (wdog_count == 17'h0_0001);

  // Divide by 128 then count down; restart command reloads both
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wdog_div   <= 7'h00;
      wdog_count <= load_count(RST_WATCHDOG_MODE[15:0]);
    end else if (restart_cmd) begin
      wdog_div   <= 7'h00;
      wdog_count <= load_count(wdog_mode.watchdog_load_value);
    end else begin
      if (slow_tick) begin
        wdog_div <= wdog_div + 7'h01;
      end
      if (wdog_event) begin
        wdog_count <= load_count(wdog_mode.watchdog_load_value);
      end else if (wdog_step) begin
        wdog_count <= wdog_count - 17'h0_0001;
      end
    end
  end

  // Internal reset request, one cycle per overflow
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      RESET_REQ <= 1'b0;
    end else begin
      RESET_REQ <= wdog_event && wdog_mode.overflow_reset_enable;
    end
  end

  // Overflow pin low for eight slow clock cycles
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pin_left       <= 4'h0;
      OVERFLOW_OUT_N <= 1'b1;
    end else if (wdog_event && wdog_mode.overflow_pin_enable) begin
      pin_left       <= PIN_LOW_CYCLES;
      OVERFLOW_OUT_N <= 1'b0;
    end else if (slow_tick && (pin_left != 4'h0)) begin
      pin_left <= pin_left - 4'h1;
      if (pin_left == 4'h1) begin
        OVERFLOW_OUT_N <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Seconds counter and alarm

  logic [16:0]    presc_count;
  logic           second_event;
  logic [19:0]    seconds_count_value;
  logic           alarm_event;

  assign second_event = slow_tick && (presc_count == 17'h0_0001);

  // Prescaler mode write restarts the divider and clears the seconds
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      presc_count         <= load_count(RST_PRESCALER_MODE[15:0]);
      seconds_count_value <= 20'h0_0000;
    end else if (wr_hit(OFS_PRESCALER_MODE)) begin
      presc_count <= load_count(presc_word[15:0]);
      seconds_count_value <= 20'h0_0000;
    end else if (second_event) begin
      presc_count         <= load_count(seconds_prescaler);
      seconds_count_value <= seconds_count_value + 20'h0_0001;
    end else if (slow_tick) begin
      presc_count <= presc_count - 17'h0_0001;
    end
  end

  // Match is checked on the value the counter just stepped to
  logic           second_seen;

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      second_seen <= 1'b0;
    end else begin
      second_seen <= second_event;
    end
  end

  assign alarm_event = second_seen
                       && (seconds_count_value == alarm_compare_value);

  ////////////////////////////////////////////////////////////////////////
  // Status flags, mask and interrupt

  timer_flags_t   status_flags;
  timer_flags_t   irq_mask;
  timer_flags_t   event_now;

  always_comb begin
    event_now                       = '0;
    event_now.interval_elapsed_flag = interval_event;
    event_now.watchdog_expired_flag = wdog_event;
    event_now.seconds_tick_flag     = second_event;
    event_now.alarm_match_flag      = alarm_event;
  end

  // Sticky flags; a status read clears, a new event wins
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      status_flags <= '0;
    end else if (status_read) begin
      status_flags <= event_now;
    end else begin
      status_flags <= status_flags | event_now;
    end
  end

  // Mask set and clear by writing ones
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      irq_mask <= '0;
    end else if (wr_hit(OFS_IRQ_ENABLE_SET) && wr_strb[0]) begin
      irq_mask <= irq_mask | wr_data[NUM_SOURCES-1:0];
    end else if (wr_hit(OFS_IRQ_ENABLE_CLR) && wr_strb[0]) begin
      irq_mask <= irq_mask & ~wr_data[NUM_SOURCES-1:0];
    end
  end

  // Active-high level, one wire to OR with other system sources
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_flags & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    read_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      OFS_INTERVAL_MODE:  read_word = {16'h0000, interval_load_value};
      OFS_WATCHDOG_MODE:  read_word = wdog_mode;
      OFS_PRESCALER_MODE: read_word = {16'h0000, seconds_prescaler};
      OFS_TIMER_STATUS:   read_word = {28'h000_0000, status_flags};
      OFS_IRQ_MASK_VIEW:  read_word = {28'h000_0000, irq_mask};
      OFS_SECONDS_ALARM:  read_word = {12'h000, alarm_compare_value};
      OFS_SECONDS_COUNT:  read_word = {12'h000, seconds_count_value};
      default:            read_word = 32'h0000_0000;
    endcase
  end

  // One read at a time; data captured when the address is taken
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (do_read) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= read_word;
      S_AXI_RRESP   <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

endmodule : slow_clock_system_timer

`default_nettype wire

// ==== slow_timer_properties.sv ====
// Checker for the slow clock system timer: bus answer timing and timer outputs.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module slow_timer_properties
  import slow_timer_pkg::*;
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  // Timer outputs
  input wire logic        IRQ,
  input wire logic        OVERFLOW_OUT_N,
  input wire logic        RESET_REQ
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  // Read address taken this cycle
  logic ar_ok;
  assign ar_ok = S_AXI_ARVALID && S_AXI_ARREADY;

  ////////////////////////////////////////////////////////////////
  // Outputs idle after a reset cycle
  a_reset_idle: assert property (disable iff (1'b0)
    SRST |=> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ && OVERFLOW_OUT_N && !RESET_REQ)
    else $error("outputs not idle after reset");
  a_read_slot: assert property (ar_ok |=> S_AXI_RVALID)
    else $error("read answer late");
  a_write_slot: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer late");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_bad_addr: assert property (
    ar_ok && (S_AXI_ARADDR > 8'h24 || S_AXI_ARADDR[1:0] != 2'h0)
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_count_width: assert property (
    ar_ok && S_AXI_ARADDR == OFS_SECONDS_COUNT |=> S_AXI_RDATA[31:20] == 12'h000)
    else $error("seconds count upper bits set");
  a_mask_width: assert property (
    ar_ok && S_AXI_ARADDR == OFS_IRQ_MASK_VIEW |=> S_AXI_RDATA[31:4] == 28'h0)
    else $error("mask view upper bits set");
  a_status_okay: assert property (
    ar_ok && S_AXI_ARADDR == OFS_TIMER_STATUS
    |=> S_AXI_RDATA[31:4] == 28'h0 && S_AXI_RRESP == RESP_OKAY)
    else $error("status read malformed");
  a_reset_pulse: assert property (RESET_REQ |=> !RESET_REQ)
    else $error("reset request longer than one cycle");
  a_pin_low: assert property ($fell(OVERFLOW_OUT_N) |-> !OVERFLOW_OUT_N [*8])
    else $error("overflow pin released early");

  // Main scenarios reached
  c_reset_req: cover property (RESET_REQ);
  c_pin_low: cover property ($fell(OVERFLOW_OUT_N));
  c_irq: cover property ($rose(IRQ));

endmodule : slow_timer_properties

bind slow_clock_system_timer slow_timer_properties slow_timer_properties_i (.*);

`default_nettype wire

// ==== slow_clock_system_timer_tb.sv ====
// Self-checking bench for the slow clock system timer over AXI4-Lite.
// Assumes the package map and a slow clock far slower than SYS_CLK.
`timescale 1ns/1ps
`default_nettype none

module slow_clock_system_timer_tb
  import slow_timer_pkg::*;
;
  logic        SYS_CLK = 1'h0, SRST = 1'h1, SLOW_CLOCK = 1'h0;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [2:0]  S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
  logic [31:0] S_AXI_WDATA = 32'h0;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic        IRQ, OVERFLOW_OUT_N, RESET_REQ;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [31:0] seed = 32'hD0AF;
  int          err_count = 0, comparisons = 0, pulses = 0;

  slow_clock_system_timer slow_clock_system_timer_i (.*);

  // 20 MHz system clock
  always #25 SYS_CLK = ~SYS_CLK;

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [33:0] okv(input logic [31:0] d);
    return {RESP_OKAY, d};
  endfunction : okv

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [31:0] p;
    p = xs();
    bq.push_back(r);
    @(posedge SYS_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_AWPROT <= p[2:0];
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do @(posedge SYS_CLK); while (!(S_AXI_AWREADY && S_AXI_WREADY));
    S_AXI_AWVALID <= 1'h0;
    S_AXI_WVALID <= 1'h0;
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    logic [31:0] p;
    p = xs();
    rq.push_back(e);
    @(posedge SYS_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARPROT <= p[2:0];
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'h0;
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'h0;
  endtask : rd

  // Slow clock rising edges, then settle time for the sync
  task automatic slow(input int k);
    repeat (k) begin
      SLOW_CLOCK <= 1'h1;
      repeat (4) @(posedge SYS_CLK);
      SLOW_CLOCK <= 1'h0;
      repeat (4) @(posedge SYS_CLK);
    end
    repeat (4) @(posedge SYS_CLK);
  endtask : slow

  task automatic end_sim();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////
  // Answer monitor: oldest note against each response
  always @(posedge SYS_CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY) check({S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    if (S_AXI_BVALID && S_AXI_BREADY) check(34'(S_AXI_BRESP), 34'(bq.pop_front()));
    if (RESET_REQ) pulses++;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_count++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge SYS_CLK);
    SRST <= 1'h0;
    rd(OFS_INTERVAL_MODE, okv(RST_INTERVAL_MODE));
    rd(OFS_WATCHDOG_MODE, okv(RST_WATCHDOG_MODE));
    rd(OFS_PRESCALER_MODE, okv(RST_PRESCALER_MODE));
    rd(OFS_SECONDS_ALARM, okv(RST_SECONDS_ALARM));
    rd(OFS_TIMER_STATUS, okv(32'h0));
    rd(OFS_IRQ_MASK_VIEW, okv(32'h0));
    rd(OFS_SECONDS_COUNT, okv(32'h0));
    rd(8'h28, {RESP_SLVERR, 32'h0});
    wr(8'h30, 32'hFFFF_FFFF, RESP_SLVERR);
    r = xs();
    wr(OFS_SECONDS_ALARM, r, RESP_OKAY);
    rd(OFS_SECONDS_ALARM, okv({12'h000, r[19:0]}));
    // Interval counter: flag on third edge, read clears
    wr(OFS_INTERVAL_MODE, 32'h3, RESP_OKAY);
    slow(2);
    rd(OFS_TIMER_STATUS, okv(32'h0));
    slow(1);
    rd(OFS_TIMER_STATUS, okv(32'h1));
    rd(OFS_TIMER_STATUS, okv(32'h0));
    wr(OFS_INTERVAL_MODE, 32'h0, RESP_OKAY);
    // Seconds counter and alarm
    wr(OFS_PRESCALER_MODE, 32'h2, RESP_OKAY);
    wr(OFS_SECONDS_ALARM, 32'h2, RESP_OKAY);
    slow(2);
    rd(OFS_TIMER_STATUS, okv(32'h4));
    slow(2);
    rd(OFS_SECONDS_COUNT, okv(32'h2));
    rd(OFS_TIMER_STATUS, okv(32'hC));
    wr(OFS_PRESCALER_MODE, 32'h2, RESP_OKAY);
    rd(OFS_SECONDS_COUNT, okv(32'h0));
    slow(1);
    rd(OFS_SECONDS_COUNT, okv(32'h0));
    wr(OFS_PRESCALER_MODE, 32'h8000, RESP_OKAY);
    rd(OFS_TIMER_STATUS, okv(32'h0));
    // Mask set and clear, then interrupt from an interval event
    wr(OFS_IRQ_ENABLE_SET, 32'hF, RESP_OKAY);
    rd(OFS_IRQ_MASK_VIEW, okv(32'hF));
    wr(OFS_IRQ_ENABLE_CLR, 32'h5, RESP_OKAY);
    rd(OFS_IRQ_MASK_VIEW, okv(32'hA));
    wr(OFS_IRQ_ENABLE_CLR, 32'hF, RESP_OKAY);
    wr(OFS_IRQ_ENABLE_SET, 32'h1, RESP_OKAY);
    wr(OFS_INTERVAL_MODE, 32'h1, RESP_OKAY);
    slow(1);
    check(34'(IRQ), 34'h1);
    wr(OFS_INTERVAL_MODE, 32'h0, RESP_OKAY);
    rd(OFS_TIMER_STATUS, okv(32'h1));
    repeat (3) @(posedge SYS_CLK);
    check(34'(IRQ), 34'h0);
    // Watchdog with pin and reset request enabled, load one
    wr(OFS_WATCHDOG_MODE, 32'h0003_0001, RESP_OKAY);
    wr(OFS_TIMER_COMMAND, 32'h1, RESP_OKAY);
    slow(120);
    check(34'(pulses), 34'h0);
    slow(8);
    check(34'(pulses), 34'h1);
    check(34'(OVERFLOW_OUT_N), 34'h0);
    slow(7);
    check(34'(OVERFLOW_OUT_N), 34'h0);
    slow(1);
    check(34'(OVERFLOW_OUT_N), 34'h1);
    rd(OFS_TIMER_STATUS, okv(32'h2));
    // Mode write mid-count must not reload; no pin or reset now
    wr(OFS_WATCHDOG_MODE, 32'h1, RESP_OKAY);
    wr(OFS_TIMER_COMMAND, 32'h1, RESP_OKAY);
    slow(100);
    wr(OFS_WATCHDOG_MODE, 32'h2, RESP_OKAY);
    slow(28);
    rd(OFS_TIMER_STATUS, okv(32'h2));
    check(34'(pulses), 34'h1);
    check(34'(OVERFLOW_OUT_N), 34'h1);
    repeat (4) @(posedge SYS_CLK);
    end_sim();
  end

endmodule : slow_clock_system_timer_tb

`default_nettype wire
